// ### fault_timer_pkg.sv
// Shared constants and types for the current-limit fault timer
package fault_timer_pkg;

    localparam int          NUM_CH             = 4;
    localparam int          CNT_W              = 28;
    localparam int          DEC_W              = 4;
    localparam logic [3:0]  DEC_LAST           = 4'hF;
    localparam logic [7:0]  TIMING_CFG_CMD     = 8'h16;
    localparam logic [7:0]  TIMING_CFG_RESET   = 8'h00;
    localparam int          OVERLOAD_TIMEOUT_SELECT_LSB           = 6;
    localparam int          OVERLOAD_TIMEOUT_SELECT_W             = 2;
    localparam int          CLK_PERIOD_NS      = 4;
    localparam int          NOMINAL_TIMEOUT_MS = 60;
    localparam int          COOL_DOWN_MS       = 1000;
    localparam int          NOMINAL_TIMEOUT_CYC =
        NOMINAL_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          COOL_DOWN_CYC      =
        COOL_DOWN_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic {CH_ARMED, CH_COOLING} ch_state_t;

endpackage

// ### fault_channel.sv
// One channel's fault counter, decay divider and cool-down timer
module fault_channel
    import fault_timer_pkg::*;
(
    input  wire logic                         clock,
    input  wire logic                         rst_b,
    input  wire logic                         restart,
    input  wire logic [fault_timer_pkg::CNT_W-1:0] timeout,
    input  wire logic [fault_timer_pkg::CNT_W-1:0] cool_len,
    input  wire logic                         startup_done,
    input  wire logic                         at_clamp,
    input  wire logic                         turn_off,
    input  wire logic                         semiauto,
    output logic                              fault_off,
    output logic                              cooling,
    output logic                              detect_start,
    output logic [fault_timer_pkg::CNT_W-1:0] fault_count
);

    ch_state_t          state_r;
    ch_state_t          state_nxt;
    logic [CNT_W-1:0]   count_r;
    logic [CNT_W-1:0]   count_nxt;
    logic [CNT_W-1:0]   cool_r;
    logic [CNT_W-1:0]   cool_nxt;
    logic [DEC_W-1:0]   dec_r;
    logic [DEC_W-1:0]   dec_nxt;
    logic               off_nxt;
    logic               det_nxt;
    logic [CNT_W-1:0]   count_inc;
    logic [CNT_W-1:0]   cool_inc;

    assign count_inc = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
    assign cool_inc  = cool_r + {{(CNT_W-1){1'b0}}, 1'b1};

    always_comb
    begin
        state_nxt = state_r;
        count_nxt = count_r;
        cool_nxt  = cool_r;
        dec_nxt   = dec_r;
        off_nxt   = 1'b0;
        det_nxt   = 1'b0;
        // Cool-down keeps running through turn-off; only the count and decay divider clear
        if (state_r == CH_COOLING)
        begin
            if (cool_inc >= cool_len)
            begin
                state_nxt = CH_ARMED;
                cool_nxt  = '0;
                det_nxt   = semiauto;
            end
            else
            begin
                cool_nxt = cool_inc;
            end
        end
        if (turn_off)
        begin
            count_nxt = '0;
            dec_nxt   = '0;
        end
        else if (restart)
        begin
            count_nxt = '0;
            dec_nxt   = '0;
        end
        else if (state_r == CH_ARMED)
        begin
            if (startup_done && at_clamp)
            begin
                dec_nxt = '0;
                if (count_inc >= timeout)
                begin
                    count_nxt = '0;
                    off_nxt   = 1'b1;
                    state_nxt = CH_COOLING;
                    cool_nxt  = '0;
                end
                else
                begin
                    count_nxt = count_inc;
                end
            end
            else if (!at_clamp)
            begin
                // Sixteen cycles per step; stops at zero rather than wrap
                dec_nxt = dec_r + 4'h1;
                if (dec_r == DEC_LAST && count_r != '0)
                begin
                    count_nxt = count_r - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r      <= CH_ARMED;
            count_r      <= '0;
            cool_r       <= '0;
            dec_r        <= '0;
            fault_off    <= 1'b0;
            detect_start <= 1'b0;
        end
        else
        begin
            state_r      <= state_nxt;
            count_r      <= count_nxt;
            cool_r       <= cool_nxt;
            dec_r        <= dec_nxt;
            fault_off    <= off_nxt;
            detect_start <= det_nxt;
        end
    end

    assign cooling     = (state_r == CH_COOLING);
    assign fault_count = count_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_clear_on_off: assert property (turn_off |=> count_r == '0)
        else $error("fault count not cleared by turn-off");
    a_restart_clear: assert property (restart && !turn_off |=> count_r == '0)
        else $error("fault count not cleared by timeout change");
    a_hold_before_start: assert property (
        !startup_done && !turn_off && !restart |=> count_r <= $past(count_r))
        else $error("fault count rose before startup expiry");
    a_count_up: assert property (
        state_r == CH_ARMED && startup_done && at_clamp && !turn_off
        && !restart && count_inc < timeout
        |=> count_r == $past(count_r) + 1)
        else $error("fault count did not advance at the clamp");
    a_fault_off: assert property (
        state_r == CH_ARMED && startup_done && at_clamp && !turn_off
        && !restart && count_inc >= timeout |=> fault_off && cooling)
        else $error("channel not powered off at timeout");
    a_cool_hold: assert property (
        cooling && cool_inc < cool_len |=> cooling)
        else $error("cool-down ended early");
    a_no_underflow: assert property (
        state_r == CH_ARMED && count_r == '0 && !at_clamp |=> count_r == '0)
        else $error("fault count went below zero");
    a_decay_step: assert property (
        state_r == CH_ARMED && !at_clamp && !turn_off && !restart
        && dec_r == DEC_LAST && count_r != '0
        |=> count_r == $past(count_r) - 1)
        else $error("fault count did not decay on the sixteenth cycle");
    a_semiauto_detect: assert property (
        cooling && cool_inc >= cool_len && semiauto |=> detect_start && !cooling)
        else $error("no detection restart after cool-down");

    c_fault: cover property (fault_off);
    c_cool_end: cover property (cooling ##1 !cooling);
    c_decay: cover property (!at_clamp && dec_r == DEC_LAST && count_r != '0);
    c_restart: cover property (restart && count_r != '0);

endmodule

// ### current_limit_fault_timer.sv
// Four-channel current-limit fault timer with its timing configuration byte
module current_limit_fault_timer
    import fault_timer_pkg::*;
#(
    parameter logic [fault_timer_pkg::CNT_W-1:0] TIMEOUT_SEL0_CYC =
        fault_timer_pkg::CNT_W'(fault_timer_pkg::NOMINAL_TIMEOUT_CYC),
    parameter logic [fault_timer_pkg::CNT_W-1:0] TIMEOUT_SEL1_CYC =
        fault_timer_pkg::CNT_W'(fault_timer_pkg::NOMINAL_TIMEOUT_CYC),
    parameter logic [fault_timer_pkg::CNT_W-1:0] TIMEOUT_SEL2_CYC =
        fault_timer_pkg::CNT_W'(fault_timer_pkg::NOMINAL_TIMEOUT_CYC),
    parameter logic [fault_timer_pkg::CNT_W-1:0] TIMEOUT_SEL3_CYC =
        fault_timer_pkg::CNT_W'(fault_timer_pkg::NOMINAL_TIMEOUT_CYC),
    parameter logic [fault_timer_pkg::CNT_W-1:0] FOLDBACK_TIMEOUT_CYC =
        fault_timer_pkg::CNT_W'(fault_timer_pkg::NOMINAL_TIMEOUT_CYC),
    parameter logic [fault_timer_pkg::CNT_W-1:0] COOL_CYC =
        fault_timer_pkg::CNT_W'(fault_timer_pkg::COOL_DOWN_CYC)
)
(
    input  wire logic                                clock,
    input  wire logic                                rst_b,
    input  wire logic [7:0]                          cmd_code,
    input  wire logic                                cmd_wr,
    input  wire logic                                cmd_rd,
    input  wire logic [7:0]                          cmd_wdata,
    output logic [7:0]                               cmd_rdata,
    output logic                                     cmd_rvalid,
    input  wire logic [fault_timer_pkg::NUM_CH-1:0]  startup_interval_timer,
    input  wire logic [fault_timer_pkg::NUM_CH-1:0]  output_current_clamp_level,
    input  wire logic [fault_timer_pkg::NUM_CH-1:0]  double_foldback_select,
    input  wire logic [fault_timer_pkg::NUM_CH-1:0]  power_off_cmd,
    input  wire logic [fault_timer_pkg::NUM_CH-1:0]  reset_cmd,
    input  wire logic                                fast_shutdown_input,
    input  wire logic [fault_timer_pkg::NUM_CH-1:0]  shutdown_select,
    input  wire logic                                semiauto_mode,
    output logic [fault_timer_pkg::NUM_CH-1:0]       fault_power_off,
    output logic [fault_timer_pkg::NUM_CH-1:0]       cool_down_active,
    output logic [fault_timer_pkg::NUM_CH-1:0]       detect_restart
);

    logic [7:0]             timing_configuration_r;
    logic [7:0]             timing_configuration_nxt;
    logic                   cfg_change_r;
    logic                   cfg_change_nxt;
    logic [7:0]             rdata_nxt;
    logic                   rvalid_nxt;
    logic [OVERLOAD_TIMEOUT_SELECT_W-1:0]      overload_timeout_select;
    logic [CNT_W-1:0]       timeout_r   [NUM_CH];
    logic [CNT_W-1:0]       timeout_nxt [NUM_CH];
    logic [NUM_CH-1:0]      turn_off;
    logic                   cfg_hit;

    // Decode of the timeout field; foldback channels use their own figure
    function automatic logic [CNT_W-1:0] timeout_cycles
    (
        input logic [OVERLOAD_TIMEOUT_SELECT_W-1:0] sel,
        input logic              dfb
    );
        logic [CNT_W-1:0] t;
        t = TIMEOUT_SEL0_CYC;
        if (dfb)
        begin
            t = FOLDBACK_TIMEOUT_CYC;
        end
        else
        begin
            case (sel)
                2'h0:    t = TIMEOUT_SEL0_CYC;
                2'h1:    t = TIMEOUT_SEL1_CYC;
                2'h2:    t = TIMEOUT_SEL2_CYC;
                2'h3:    t = TIMEOUT_SEL3_CYC;
                default: t = TIMEOUT_SEL0_CYC;
            endcase
        end
        return t;
    endfunction

    assign cfg_hit = (cmd_code == TIMING_CFG_CMD);
    assign overload_timeout_select =
        timing_configuration_r[OVERLOAD_TIMEOUT_SELECT_LSB +: OVERLOAD_TIMEOUT_SELECT_W];

    always_comb
    begin
        timing_configuration_nxt = timing_configuration_r;
        cfg_change_nxt           = 1'b0;
        rdata_nxt                = cmd_rdata;
        rvalid_nxt               = 1'b0;
        if (cmd_wr && cfg_hit)
        begin
            timing_configuration_nxt = cmd_wdata;
            // Only a new timeout value restarts the timers, not a rewrite
            cfg_change_nxt = (cmd_wdata[OVERLOAD_TIMEOUT_SELECT_LSB +: OVERLOAD_TIMEOUT_SELECT_W]
                              != overload_timeout_select);
        end
        if (cmd_rd && cfg_hit)
        begin
            rdata_nxt  = timing_configuration_r;
            rvalid_nxt = 1'b1;
        end
        for (int i = 0; i < NUM_CH; i++)
        begin
            // One shared field, decoded per channel for foldback
            timeout_nxt[i] = timeout_cycles(overload_timeout_select,
                                            double_foldback_select[i]);
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timing_configuration_r <= TIMING_CFG_RESET;
            cfg_change_r           <= 1'b0;
            cmd_rdata              <= 8'h00;
            cmd_rvalid             <= 1'b0;
            for (int i = 0; i < NUM_CH; i++)
            begin
                timeout_r[i] <= TIMEOUT_SEL0_CYC;
            end
        end
        else
        begin
            timing_configuration_r <= timing_configuration_nxt;
            cfg_change_r           <= cfg_change_nxt;
            cmd_rdata              <= rdata_nxt;
            cmd_rvalid             <= rvalid_nxt;
            for (int i = 0; i < NUM_CH; i++)
            begin
                timeout_r[i] <= timeout_nxt[i];
            end
        end
    end

    // Fast shutdown hits only the channels picked by shutdown_select
    assign turn_off = power_off_cmd | reset_cmd
                    | ({NUM_CH{fast_shutdown_input}} & shutdown_select);

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        fault_channel u_ch
        (
            .clock        (clock),
            .rst_b        (rst_b),
            .restart      (cfg_change_r),
            .timeout      (timeout_r[g]),
            .cool_len     (COOL_CYC),
            .startup_done (startup_interval_timer[g]),
            .at_clamp     (output_current_clamp_level[g]),
            .turn_off     (turn_off[g]),
            .semiauto     (semiauto_mode),
            .fault_off    (fault_power_off[g]),
            .cooling      (cool_down_active[g]),
            .detect_start (detect_restart[g]),
            .fault_count  ()
        );
    end

    a_cfg_write: assert property (@(posedge clock) disable iff (!rst_b)
        cmd_wr && cfg_hit |=> timing_configuration_r == $past(cmd_wdata))
        else $error("timing byte not written");
    a_cfg_read: assert property (@(posedge clock) disable iff (!rst_b)
        cmd_rd && cfg_hit && !cmd_wr
        |=> cmd_rvalid && cmd_rdata == $past(timing_configuration_r))
        else $error("timing byte read wrong");
    a_nominal_sel: assert property (@(posedge clock) disable iff (!rst_b)
        !double_foldback_select[0] && !cmd_wr
        |=> ##1 (timeout_r[0] == timeout_cycles($past(overload_timeout_select, 2),
                 1'b0)))
        else $error("nominal timeout not applied");

endmodule

// ### host_model.sv
// Host model driving the timing configuration command port
module host_model
(
    input  wire logic       clock,
    output logic [7:0]      cmd_code,
    output logic            cmd_wr,
    output logic            cmd_rd,
    output logic [7:0]      cmd_wdata,
    input  wire logic [7:0] cmd_rdata,
    input  wire logic       cmd_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cmd_code = 8'h00;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_wdata = 8'h00;
    end

    // Single-byte write held across exactly one rising edge
    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        @(negedge clock);
        cmd_code = code;
        cmd_wdata = data;
        cmd_wr = 1'b1;
        @(negedge clock);
        cmd_wr = 1'b0;
        // Released data is inverted so a stale byte cannot pass
        cmd_wdata = ~data;
    endtask

    // Single-byte read; the answer stands only in the cycle after the taking
    // edge, so it is taken at the falling edge that releases the request
    task automatic rd(input logic [7:0] code, output logic [7:0] data,
                      output logic ok);
        @(negedge clock);
        cmd_code = code;
        cmd_rd = 1'b1;
        @(negedge clock);
        cmd_rd = 1'b0;
        ok = cmd_rvalid;
        data = cmd_rdata;
    endtask
endmodule

// ### tb_current_limit_fault_timer.sv
// Testbench for the four-channel current-limit fault timer
module tb_current_limit_fault_timer;
    timeunit 1ns;
    timeprecision 1ps;
    import fault_timer_pkg::*;

    // Shortened counts so each fault cycle takes tens of clocks
    localparam int TSEL [4] = '{20, 24, 28, 32};
    localparam int FB = 12;
    localparam int COOL = 40;

    logic       clock;
    logic       rst_b;
    logic [3:0] st;
    logic [3:0] clamp;
    logic [3:0] dfb;
    logic [3:0] poff;
    logic [3:0] rcmd;
    logic [3:0] ssel;
    logic       fsd;
    logic       semi;
    logic [7:0] code;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       wr;
    logic       rd;
    logic       rvalid;
    logic [3:0] fault;
    logic [3:0] cool;
    logic [3:0] restart;
    int         mismatches;
    int         compares;

    current_limit_fault_timer #(
        .TIMEOUT_SEL0_CYC(CNT_W'(TSEL[0])),
        .TIMEOUT_SEL1_CYC(CNT_W'(TSEL[1])),
        .TIMEOUT_SEL2_CYC(CNT_W'(TSEL[2])),
        .TIMEOUT_SEL3_CYC(CNT_W'(TSEL[3])),
        .FOLDBACK_TIMEOUT_CYC(CNT_W'(FB)),
        .COOL_CYC(CNT_W'(COOL))
    ) i_current_limit_fault_timer (
        .clock(clock), .rst_b(rst_b), .cmd_code(code), .cmd_wr(wr),
        .cmd_rd(rd), .cmd_wdata(wdata), .cmd_rdata(rdata),
        .cmd_rvalid(rvalid), .startup_interval_timer(st),
        .output_current_clamp_level(clamp), .double_foldback_select(dfb),
        .power_off_cmd(poff), .reset_cmd(rcmd), .fast_shutdown_input(fsd),
        .shutdown_select(ssel), .semiauto_mode(semi),
        .fault_power_off(fault), .cool_down_active(cool),
        .detect_restart(restart)
    );

    host_model i_host_model (
        .clock(clock), .cmd_code(code), .cmd_wr(wr), .cmd_rd(rd),
        .cmd_wdata(wdata), .cmd_rdata(rdata), .cmd_rvalid(rvalid)
    );

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Clamp a channel for n cycles, then release it
    task automatic pump(input int ch, input int n);
        @(negedge clock);
        clamp[ch] = 1'b1;
        repeat (n) @(negedge clock);
        clamp[ch] = 1'b0;
    endtask

    // Clamp until turn-off, then hold the clamp through cool-down
    task automatic fire(input int ch, input int t);
        int   n;
        logic again;
        n = 0;
        again = 1'b0;
        @(negedge clock);
        clamp[ch] = 1'b1;
        while (n < 1000 && fault[ch] !== 1'b1)
        begin
            @(negedge clock);
            n++;
        end
        check("timeout cycles", n, t);
        check("other channels", fault & ~(4'h1 << ch), 0);
        n = 1;
        while (n < 1000 && cool[ch] === 1'b1)
        begin
            @(negedge clock);
            again |= (fault !== 4'h0);
            n += (cool[ch] === 1'b1);
        end
        check("cool cycles", n, COOL);
        check("turn-on while cooling", again, 0);
        check("detect restart", restart, {3'h0, semi} << ch);
        clamp[ch] = 1'b0;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        stop_test();
    end

    initial
    begin
        logic [7:0] d;
        logic       ok;
        mismatches = 0;
        compares = 0;
        rst_b = 1'b0;
        st = 4'hF;
        clamp = 4'h0;
        dfb = 4'h0;
        poff = 4'h0;
        rcmd = 4'h0;
        ssel = 4'h0;
        fsd = 1'b0;
        semi = 1'b0;
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        i_host_model.rd(8'h16, d, ok);
        check("reset byte", {ok, d}, 9'h100);
        i_host_model.wr(8'h16, 8'hC0);
        i_host_model.rd(8'h16, d, ok);
        check("readback", {ok, d}, 9'h1C0);
        i_host_model.rd(8'h17, d, ok);
        check("unmapped answer", ok, 0);
        $display("test registers done");
        // Each timeout code on its own channel, semiauto on odd codes
        for (int s = 0; s < 4; s++)
        begin
            i_host_model.wr(8'h16, 8'(s << OVERLOAD_TIMEOUT_SELECT_LSB));
            semi = s[0];
            repeat (4) @(negedge clock);
            fire(s, TSEL[s]);
        end
        dfb[1] = 1'b1;
        fire(1, FB);
        dfb[1] = 1'b0;
        $display("test timeouts done");
        st[2] = 1'b0;
        clamp[2] = 1'b1;
        repeat (80) @(negedge clock);
        // Drop the clamp first so no count starts before fire takes over
        clamp[2] = 1'b0;
        st[2] = 1'b1;
        fire(2, TSEL[3]);
        $display("test startup gate done");
        // Two decay steps over 41 idle cycles, then saturation at zero
        pump(0, 28);
        repeat (40) @(negedge clock);
        fire(0, 6);
        pump(0, 3);
        repeat (200) @(negedge clock);
        fire(0, TSEL[3]);
        $display("test decay done");
        // Power-off, reset command, fast shutdown, unselected shutdown
        for (int k = 0; k < 4; k++)
        begin
            pump(3, 30);
            poff[3] = (k == 0);
            rcmd[3] = (k == 1);
            fsd = (k >= 2);
            ssel[3] = (k == 2);
            @(negedge clock);
            poff = 4'h0;
            rcmd = 4'h0;
            fsd = 1'b0;
            fire(3, (k == 3) ? 2 : TSEL[3]);
        end
        $display("test turn-off clear done");
        i_host_model.wr(8'h16, 8'h00);
        repeat (4) @(negedge clock);
        pump(0, 18);
        i_host_model.wr(8'h16, 8'h80);
        repeat (4) @(negedge clock);
        fire(0, TSEL[2]);
        $display("test timeout rewrite done");
        stop_test();
    end
endmodule
